/* verilog/rtws_pkg.sv */
// Shared constants and types for the clock/calendar two-wire slave port.
// Assumes a single core clock and SCL arriving as the link clock.
package rtws_pkg;

   // Seven-bit bus address; the address byte with write direction reads D0h.
   localparam logic [6:0] SLV_ADDR = 7'h68;

   // Pointer width and layout of the eight byte locations.
   localparam int LOC_W = 3;
   localparam logic [LOC_W-1:0] PTR_RST = 3'h0;
   localparam logic [LOC_W-1:0] PTR_STEP = 3'h1;

   // Bit counter values: last data bit and the acknowledge slot.
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [3:0] CNT_LAST = 4'h7;
   localparam logic [3:0] CNT_ACK = 4'h8;
   localparam logic [3:0] CNT_STEP = 4'h1;

   // Position of the direction bit in the address byte; a one asks for a read.
   localparam int RW_POS = 0;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_word,
      st_wdata,
      st_rdata
   } rtws_state_t;

   // Write strobe towards the timekeeping core.
   typedef struct packed {
      logic valid;
      logic [LOC_W-1:0] addr;
      logic [7:0] data;
   } rtws_wr_t;

endpackage : rtws_pkg

/* verilog/rtws_slave.sv */
// Two-wire slave access port of the clock/calendar byte file.
// Assumes SCL doubles as the link clock and that the timekeeping core
// answers rd_data_i combinationally from ptr_o in the core clock domain.
`timescale 1ns/1ps

module rtws_slave #(
   parameter logic [6:0] SLAVE_ADDR = rtws_pkg::SLV_ADDR
) (
   input wire logic mclk_i, // Core clock, 100 MHz.
   input wire logic rstn_i, // Asynchronous reset, active low.
   input wire logic scl_clk_i, // Bus clock pin, also the link clock.
   input wire logic sda_i, // Bus data pin level.
   output logic sda_o, // Data drive value, always low.
   output logic sda_oe_o, // High while the device pulls SDA low.
   input wire logic vcc_ok_i, // Main supply above switchover, asynchronous.
   input wire logic [7:0] rd_data_i, // Byte at ptr_o from the core.
   output logic [rtws_pkg::LOC_W-1:0] ptr_o, // Word address pointer.
   output rtws_pkg::rtws_wr_t wr_o, // One-cycle write strobe.
   output logic busy_o // High from a START until the transfer ends or its address does not match.
);
   import rtws_pkg::*;

   if (SLAVE_ADDR[6:3] == 4'h0 || SLAVE_ADDR[6:3] == 4'hf) begin : g_chk
      $error("SLAVE_ADDR lies in a reserved address group");
   end

   // Link domain: SDA is taken on each SCL rise and a toggle marks it.
   // The sampled bit then holds for a whole SCL period, far longer than
   // the core needs to see the synchronised toggle.
   logic lk_tgl;
   logic lk_bit;
   logic next_lk_tgl;

   always_comb begin
      next_lk_tgl = ~lk_tgl;
   end

   always_ff @(posedge scl_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lk_tgl <= 1'b0;
         lk_bit <= 1'b1;
      end else begin
         lk_tgl <= next_lk_tgl;
         lk_bit <= sda_i;
      end
   end

   // Core domain synchronisers; the third stage serves edge detection.
   logic tgl_s1, tgl_s2, tgl_s3;
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic vcc_s1, vcc_s2;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
         vcc_s1 <= 1'b0;
         vcc_s2 <= 1'b0;
      end else begin
         tgl_s1 <= lk_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
         scl_s1 <= scl_clk_i;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         vcc_s1 <= vcc_ok_i;
         vcc_s2 <= vcc_s1;
      end
   end

   logic rise_ev, fall_ev, start_ev, stop_ev, pfail;
   logic [7:0] rx_byte;

   assign rise_ev = tgl_s2 ^ tgl_s3;
   assign fall_ev = scl_s3 & ~scl_s2;
   assign start_ev = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop_ev = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   assign pfail = ~vcc_s2;

   rtws_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [7:0] shreg, next_shreg;
   logic [LOC_W-1:0] ptr, next_ptr;
   logic sda_oe, next_sda_oe;
   logic load, next_load;
   rtws_wr_t wr, next_wr;

   assign rx_byte = {shreg[6:0], lk_bit};

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shreg = shreg;
      next_ptr = ptr;
      next_sda_oe = sda_oe;
      next_load = 1'b0;
      next_wr = wr;
      next_wr.valid = 1'b0;
      if (pfail) begin
         // Bus inputs are ignored and the pointer cleared until supply returns.
         next_state = st_idle;
         next_cnt = CNT_RST;
         next_ptr = PTR_RST;
         next_sda_oe = 1'b0;
      end else if (start_ev) begin
         // A START also discards the bit clocked by its own SCL high phase.
         next_state = st_addr;
         next_cnt = CNT_RST;
         next_sda_oe = 1'b0;
      end else if (stop_ev) begin
         next_state = st_idle;
         next_sda_oe = 1'b0;
      end else begin
         if (load) begin
            next_shreg = rd_data_i;
         end
         if (rise_ev && state != st_idle) begin
            if (cnt != CNT_ACK) begin
               next_cnt = cnt + CNT_STEP;
               if (state == st_rdata) begin
                  next_shreg = {shreg[6:0], 1'b1};
               end else begin
                  next_shreg = rx_byte;
               end
               if (cnt == CNT_LAST) begin
                  if (state == st_addr && rx_byte[7:1] != SLAVE_ADDR) begin
                     next_state = st_idle;
                  end
                  if (state == st_word) begin
                     next_ptr = rx_byte[LOC_W-1:0];
                  end
                  if (state == st_wdata) begin
                     next_wr.valid = 1'b1;
                     next_wr.addr = ptr;
                     next_wr.data = rx_byte;
                  end
               end
            end else begin
               // Acknowledge slot clocked in.
               next_cnt = CNT_RST;
               unique case (state)
                  st_addr: begin
                     if (shreg[RW_POS]) begin
                        next_state = st_rdata;
                        next_shreg = rd_data_i;
                     end else begin
                        next_state = st_word;
                     end
                  end
                  st_word: next_state = st_wdata;
                  st_wdata: next_ptr = ptr + PTR_STEP;
                  st_rdata: begin
                     if (!lk_bit) begin
                        next_ptr = ptr + PTR_STEP;
                        next_load = 1'b1;
                     end else begin
                        next_state = st_idle;
                     end
                  end
                  st_idle: next_state = st_idle;
               endcase
            end
         end
         // Drive changes only just after SCL falls, so SDA stays steady while SCL is high.
         if (fall_ev) begin
            if (state == st_rdata) begin
               next_sda_oe = (cnt != CNT_ACK) & ~shreg[7];
            end else begin
               next_sda_oe = (cnt == CNT_ACK) & (state != st_idle);
            end
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= st_idle;
         cnt <= CNT_RST;
         shreg <= 8'hff;
         ptr <= PTR_RST;
         sda_oe <= 1'b0;
         load <= 1'b0;
         wr <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         shreg <= next_shreg;
         ptr <= next_ptr;
         sda_oe <= next_sda_oe;
         load <= next_load;
         wr <= next_wr;
      end
   end

   // Outputs registered straight from the state above or their own flops.
   logic busy;
   assign sda_oe_o = sda_oe;
   assign ptr_o = ptr;
   assign wr_o = wr;
   assign busy_o = busy;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         busy <= (next_state != st_idle);
         sda_o <= 1'b0;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_byte_end;
      rise_ev && cnt == CNT_LAST && !pfail && !start_ev && !stop_ev;
   endsequence

   sequence s_ack_rise;
      rise_ev && cnt == CNT_ACK && !pfail && !start_ev && !stop_ev;
   endsequence

   property p_ack_rx;
      fall_ev && cnt == CNT_ACK && !pfail && !start_ev && !stop_ev
         && (state == st_addr || state == st_word || state == st_wdata) |=> sda_oe_o;
   endproperty
   a_ack_rx: assert property (p_ack_rx) else $error("received byte not acknowledged");

   property p_nomatch;
      s_byte_end and (state == st_addr && rx_byte[7:1] != SLAVE_ADDR)
         |=> state == st_idle && !sda_oe_o ##1 !busy_o;
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("foreign address not ignored");

   property p_ptr_load;
      logic [LOC_W-1:0] a;
      (s_byte_end and state == st_word, a = rx_byte[LOC_W-1:0]) |=> ptr_o == a;
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer byte not loaded");

   property p_wr_store;
      (s_byte_end and state == st_wdata)
         |=> wr_o.valid && wr_o.addr == $past(ptr) && wr_o.data == $past(rx_byte);
   endproperty
   a_wr_store: assert property (p_wr_store) else $error("write strobe wrong");

   property p_wr_adv;
      (s_ack_rise and state == st_wdata) |=> ptr_o == LOC_W'($past(ptr) + PTR_STEP);
   endproperty
   a_wr_adv: assert property (p_wr_adv) else $error("pointer did not advance");

   property p_rd_nack;
      (s_ack_rise and state == st_rdata && lk_bit)
         |=> state == st_idle && ptr_o == $past(ptr) && !sda_oe_o;
   endproperty
   a_rd_nack: assert property (p_rd_nack) else $error("read not ended on nack");

   property p_rd_next;
      (s_ack_rise and state == st_rdata && !lk_bit)
         |=> ptr_o == LOC_W'($past(ptr) + PTR_STEP) ##1 shreg == $past(rd_data_i);
   endproperty
   a_rd_next: assert property (p_rd_next) else $error("next read byte not fetched");

   property p_rd_first;
      (s_ack_rise and state == st_addr && shreg[RW_POS])
         |=> state == st_rdata && shreg == $past(rd_data_i) && ptr_o == $past(ptr);
   endproperty
   a_rd_first: assert property (p_rd_first) else $error("read start byte wrong");

   property p_tx_bit;
      fall_ev && state == st_rdata && cnt != CNT_ACK && !pfail && !start_ev && !stop_ev
         |=> sda_oe_o == !$past(shreg[7]);
   endproperty
   a_tx_bit: assert property (p_tx_bit) else $error("data bit driven wrong");

   property p_steady;
      $changed(sda_oe_o) && !$past(pfail) && !$past(start_ev) && !$past(stop_ev)
         |-> !$past(scl_s2);
   endproperty
   a_steady: assert property (p_steady) else $error("SDA moved while SCL high");

   property p_pfail;
      pfail |=> ptr_o == PTR_RST && state == st_idle && !sda_oe_o ##1 !busy_o;
   endproperty
   a_pfail: assert property (p_pfail) else $error("supply loss did not abort");

endmodule : rtws_slave

/* tb/rtws_bus_master.sv */
// Behavioural two-wire bus master facing the slave port.
// Assumes the bench resolves SDA from both pull-down enables with a pull-up.
`timescale 1ns/1ps

module rtws_bus_master #(
   parameter int HALF = 8
) (
   input wire logic link_clk_i, // Bus timing clock, free running.
   input wire logic sda_i, // Resolved SDA level.
   output logic scl_o, // Bus clock, high while idle.
   output logic sda_oe_o // High while the master pulls SDA low.
);
   logic unstable = 1'b0; // Set when SDA moves while SCL is high.

   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge link_clk_i);
   endtask : tick

   // Data moves only in mid-low; sampled twice in the high phase.
   task automatic bit_cycle(input logic v, output logic s);
      logic s_early;
      sda_oe_o <= ~v;
      tick(HALF / 2);
      scl_o <= 1'b1;
      tick(HALF / 4);
      s_early = sda_i;
      tick(HALF / 2);
      s = sda_i;
      if (s !== s_early) unstable = 1'b1;
      tick(HALF / 4);
      scl_o <= 1'b0;
      tick(HALF / 2);
   endtask : bit_cycle

   task automatic start();
      sda_oe_o <= 1'b0;
      tick(HALF / 2);
      scl_o <= 1'b1;
      tick(HALF);
      sda_oe_o <= 1'b1;
      tick(HALF); // Hold before the first clock pulse.
      scl_o <= 1'b0;
      tick(HALF / 2);
   endtask : start

   task automatic stop();
      sda_oe_o <= 1'b1;
      tick(HALF / 2);
      scl_o <= 1'b1;
      tick(HALF);
      sda_oe_o <= 1'b0;
      tick(2 * HALF); // Bus left free before any new transfer.
   endtask : stop

   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
      bit_cycle(1'b1, s); // Extra clock with SDA released for the answer.
      ack = ~s;
   endtask : write_byte

   task automatic read_byte(input logic give_ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
      bit_cycle(~give_ack, s); // Answer clock; with give_ack low, as for the last byte, the byte is left unanswered.
   endtask : read_byte
endmodule : rtws_bus_master

/* tb/rtws_slave_tb.sv */
// Self-checking bench for the two-wire slave port with a byte-file model.
// Assumes the core answers rd_data_i from ptr_o without delay.
`timescale 1ns/1ps

module rtws_slave_tb;
   import rtws_pkg::*;

   logic mclk_i, rstn_i, vcc_ok_i, link_clk, scl, m_oe, sda, ack, dut_oe, dut_sda, busy;
   logic [7:0] rd_data;
   logic [LOC_W-1:0] ptr;
   rtws_wr_t wr;
   logic [7:0] mem [8];
   logic [7:0] exp_mem [8];
   int wr_cnt = 0;
   int bad_count = 0;
   int checks = 0;

   assign sda = ~(dut_oe | m_oe);
   assign rd_data = mem[ptr];

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // Link clock at 15 ns, offset so its edges never meet the core clock.
   initial begin
      link_clk = 1'b0;
      #3;
      forever #7.5 link_clk = ~link_clk;
   end

   always @(posedge mclk_i) begin
      if (wr.valid === 1'b1) begin
         mem[wr.addr] <= wr.data;
         wr_cnt <= wr_cnt + 1;
      end
   end

   rtws_slave u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_clk_i(scl), .sda_i(sda),
      .sda_o(dut_sda), .sda_oe_o(dut_oe), .vcc_ok_i(vcc_ok_i), .rd_data_i(rd_data),
      .ptr_o(ptr), .wr_o(wr), .busy_o(busy));

   rtws_bus_master u_mst (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      checks++;
      if (seen !== want) begin
         bad_count++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, seen, want);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   task automatic set_ptr(input logic [7:0] w);
      u_mst.start();
      u_mst.write_byte({SLV_ADDR, 1'b0}, ack);
      check({7'h0, ack}, 8'h01, "address ack");
      check({7'h0, dut_sda}, 8'h00, "drive level low");
      u_mst.write_byte(w, ack);
      check({7'h0, ack}, 8'h01, "word ack");
   endtask : set_ptr

   task automatic read_seq(input int first, input int n);
      logic [7:0] d;
      u_mst.write_byte({SLV_ADDR, 1'b1}, ack);
      check({7'h0, ack}, 8'h01, "read address ack");
      for (int i = 0; i < n; i++) begin
         u_mst.read_byte(i < n - 1, d);
         check(d, exp_mem[(first + i) % 8], "read byte");
      end
      check({7'h0, dut_oe}, 8'h00, "release after nack");
      u_mst.stop();
      check({7'h0, busy}, 8'h00, "busy after stop");
      check({5'h0, ptr}, 8'((first + n - 1) % 8), "pointer after read");
   endtask : read_seq

   // Eight bytes from location 6 cover every location and the wrap.
   task automatic t_write_burst();
      int base;
      base = wr_cnt;
      set_ptr(8'h06);
      for (int i = 0; i < 8; i++) begin
         exp_mem[(6 + i) % 8] = 8'(8'h3c + i * 8'h11);
         u_mst.write_byte(exp_mem[(6 + i) % 8], ack);
         check({7'h0, ack}, 8'h01, "data ack");
      end
      check({7'h0, busy}, 8'h01, "busy in write");
      u_mst.stop();
      check({7'h0, busy}, 8'h00, "busy after write stop");
      check({5'h0, ptr}, 8'h06, "pointer after burst");
      check(8'(wr_cnt - base), 8'h08, "write strobes");
      for (int i = 0; i < 8; i++) check(mem[i], exp_mem[i], "stored byte");
   endtask : t_write_burst

   task automatic t_random_read();
      set_ptr(8'h03);
      u_mst.start();
      read_seq(3, 3);
   endtask : t_random_read

   task automatic t_current_wrap();
      set_ptr(8'h07);
      u_mst.stop();
      check({5'h0, ptr}, 8'h07, "pointer load");
      u_mst.start();
      read_seq(7, 2);
   endtask : t_current_wrap

   task automatic t_foreign();
      int base;
      base = wr_cnt;
      u_mst.start();
      u_mst.write_byte(8'ha0, ack);
      check({7'h0, ack}, 8'h00, "foreign address");
      u_mst.write_byte({SLV_ADDR, 1'b0}, ack);
      check({7'h0, ack}, 8'h00, "no start");
      u_mst.stop();
      check({5'h0, ptr}, 8'h00, "pointer kept");
      check(8'(wr_cnt - base), 8'h00, "no strobe");
   endtask : t_foreign

   // Supply loss in mid-write must drop the access and clear the pointer.
   task automatic t_power_fail();
      int base;
      base = wr_cnt;
      set_ptr(8'h02);
      check({5'h0, ptr}, 8'h02, "pointer load");
      @(posedge mclk_i) vcc_ok_i <= 1'b0;
      repeat (6) @(posedge mclk_i);
      check({5'h0, ptr}, 8'h00, "pointer cleared");
      check({7'h0, busy}, 8'h00, "access dropped");
      u_mst.write_byte(8'hff, ack);
      check({7'h0, ack}, 8'h00, "bus ignored");
      u_mst.stop();
      check(8'(wr_cnt - base), 8'h00, "no strobe");
      @(posedge mclk_i) vcc_ok_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      u_mst.start();
      read_seq(0, 1);
   endtask : t_power_fail

   initial begin
      rstn_i = 1'b0;
      vcc_ok_i = 1'b1;
      repeat (5) @(posedge mclk_i);
      rstn_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      t_write_burst();
      t_random_read();
      t_current_wrap();
      t_foreign();
      t_power_fail();
      check({7'h0, u_mst.unstable}, 8'h00, "SDA steady while SCL high");
      final_report();
   end

   // The whole sequence needs well under 200 us.
   initial begin
      #500000;
      bad_count++;
      $display("Error at %0t ns: watchdog expired", $time);
      final_report();
   end
endmodule : rtws_slave_tb
